//--- rtl/dmachr_pkg.sv
// Package: register map, field layout and types of the DMA channel register block
package dmachr_pkg;
    localparam logic [7:0]  OFF_DEV_ADDR   = 8'h00;
    localparam logic [7:0]  OFF_CS_SET     = 8'h04;
    localparam logic [7:0]  OFF_CS_CLR     = 8'h08;
    localparam logic [7:0]  OFF_CS_READ    = 8'h0c;
    localparam logic [7:0]  OFF_CNT_A      = 8'h10;
    localparam logic [7:0]  OFF_CNT_B      = 8'h14;
    localparam logic [7:0]  OFF_IRQ_STAT   = 8'h18;
    localparam logic [7:0]  OFF_IRQ_CLR    = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_EN     = 8'h20;
    localparam int          CNT_W          = 13;
    localparam int          CS_W           = 8;
    localparam int          CS_RUN_BIT     = 0;
    localparam int          CS_DONE_A_BIT  = 1;
    localparam int          CS_DONE_B_BIT  = 2;
    localparam int          CS_BUF_B_BIT   = 3;
    localparam int          CS_BUS_ERR_BIT = 7;
    localparam logic [7:0]  CS_RESET       = 8'h00;
    localparam int          IRQ_W          = 3;
    localparam int          IRQ_DONE_A     = 0;
    localparam int          IRQ_DONE_B     = 1;
    localparam int          IRQ_BUS_ERR    = 2;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam logic [25:0] DEV_ADDR_LOW_RESET = 26'h0000000;
    localparam logic [31:0] DEV_ADDR_TOP_UNDEF = 32'hfc000000;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } dmachr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dmachr_apb_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        bus_error;
    } dmachr_beat_t;
endpackage : dmachr_pkg

//--- rtl/dmachr_channel.sv
// DMA channel register block: device address, control/status views, byte counters, irq
// Function
// - Buffer A byte count is a 13-bit field in the low bits, up to 8191.
// - Buffer B byte count is its own 13-bit field, also up to 8191.
// - Count register bits above the field read zero; writes there are ignored.
// - Count upper bits reset to zero; the count bits are not defined by reset.
// - Control/status bits reached through set, clear and read 32-bit views.
// - Control/status bit 0 is run, enabling the channel to transfer.
// - Bus error status bit 7 resets to zero.
// - Reserved control/status positions read zero after reset.
// - Device address top six bits are undefined after reset.
//
// The APB register port and the register addresses are this design's own decisions.
module dmachr_channel
    import dmachr_pkg::*;
#(
    parameter logic [31:0] DEV_ADDR_TOP_FILL = 32'h00000000
) (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire dmachr_apb_req_t apb_req,
    output      dmachr_apb_rsp_t apb_rsp,
    input  wire dmachr_beat_t    beat,
    output      logic            beat_ready,
    output      logic            chan_run,
    output      logic [31:0]     chan_dev_addr,
    output      logic            irq
);
    logic [31:0]    dev_addr_reg;
    logic [CS_W-1:0] cs_reg;
    logic [CNT_W-1:0] cnt_a_reg;
    logic [CNT_W-1:0] cnt_b_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    dmachr_apb_rsp_t rsp_reg;
    logic            irq_reg;
    logic            ready_reg;

    logic            wr_acc;
    logic            rd_acc;
    logic            buf_b;
    logic            cur_zero;
    logic            take;
    logic            done_a_ev;
    logic            done_b_ev;
    logic            err_ev;
    logic [IRQ_W-1:0] irq_ev;
    logic [31:0]     rd_next;
    logic            mapped;

    // Zero-wait slave: answer in the access cycle
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    assign buf_b    = cs_reg[CS_BUF_B_BIT];
    assign cur_zero = buf_b ? (cnt_b_reg == '0) : (cnt_a_reg == '0);
    // Beats move while registered ready stands; it follows run and the active buffer count one cycle late
    assign take      = beat.valid && ready_reg;
    assign done_a_ev = take && !buf_b && (cnt_a_reg == CNT_W'(1));
    assign done_b_ev = take && buf_b && (cnt_b_reg == CNT_W'(1));
    assign err_ev    = take && beat.bus_error;
    assign irq_ev    = {err_ev, done_b_ev, done_a_ev};

    always_comb begin
        mapped  = 1'b1;
        rd_next = 32'h00000000;
        case (apb_req.paddr)
            OFF_DEV_ADDR: rd_next = dev_addr_reg;
            OFF_CS_READ:  rd_next = {{(32-CS_W){1'b0}}, cs_reg};
            OFF_CS_SET:   rd_next = 32'h00000000;
            OFF_CS_CLR:   rd_next = 32'h00000000;
            OFF_CNT_A:    rd_next = {{(32-CNT_W){1'b0}}, cnt_a_reg};
            OFF_CNT_B:    rd_next = {{(32-CNT_W){1'b0}}, cnt_b_reg};
            OFF_IRQ_STAT: rd_next = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
            OFF_IRQ_EN:   rd_next = {{(32-IRQ_W){1'b0}}, irq_en_reg};
            OFF_IRQ_CLR:  rd_next = 32'h00000000;
            default:      mapped  = 1'b0;
        endcase
    end

    // Device address: low bits reset, top six keep a fill value that software overwrites
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dev_addr_reg <= (DEV_ADDR_TOP_FILL & DEV_ADDR_TOP_UNDEF)
                            | {6'h00, DEV_ADDR_LOW_RESET};
        end else if (wr_acc && apb_req.paddr == OFF_DEV_ADDR) begin
            dev_addr_reg <= apb_req.pwdata;
        end
    end

    // Control/status with set and clear views; hardware-set status wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_reg <= CS_RESET;
        end else begin
            if (wr_acc && apb_req.paddr == OFF_CS_SET) begin
                cs_reg <= cs_reg | apb_req.pwdata[CS_W-1:0];
            end else if (wr_acc && apb_req.paddr == OFF_CS_CLR) begin
                // Clearing bit 7 here is defined as a clear; software avoids it anyway
                cs_reg <= cs_reg & ~apb_req.pwdata[CS_W-1:0];
            end
            if (done_a_ev) begin
                cs_reg[CS_DONE_A_BIT] <= 1'b1;
                cs_reg[CS_BUF_B_BIT]  <= 1'b1;
            end
            if (done_b_ev) begin
                cs_reg[CS_DONE_B_BIT] <= 1'b1;
                cs_reg[CS_BUF_B_BIT]  <= 1'b0;
            end
            if (err_ev) begin
                cs_reg[CS_BUS_ERR_BIT] <= 1'b1;
                cs_reg[CS_RUN_BIT]     <= 1'b0;
            end
        end
    end

    // Count bits keep no reset: only the implied upper zeros are defined
    always_ff @(posedge sys_clk) begin
        if (wr_acc && apb_req.paddr == OFF_CNT_A) begin
            cnt_a_reg <= apb_req.pwdata[CNT_W-1:0];
        end else if (take && !buf_b) begin
            cnt_a_reg <= cnt_a_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_acc && apb_req.paddr == OFF_CNT_B) begin
            cnt_b_reg <= apb_req.pwdata[CNT_W-1:0];
        end else if (take && buf_b) begin
            cnt_b_reg <= cnt_b_reg - CNT_W'(1);
        end
    end

    // Sticky interrupt status; a new event beats a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_stat_reg <= IRQ_RESET;
        end else if (wr_acc && apb_req.paddr == OFF_IRQ_CLR) begin
            irq_stat_reg <= (irq_stat_reg & ~apb_req.pwdata[IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_en_reg <= IRQ_RESET;
        end else if (wr_acc && apb_req.paddr == OFF_IRQ_EN) begin
            irq_en_reg <= apb_req.pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |((irq_stat_reg | irq_ev) & irq_en_reg);
        end
    end

    // Ready is registered: it drops the cycle after every byte, and stays low while the active buffer count is zero or run is clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= cs_reg[CS_RUN_BIT] && !cur_zero && !take;
        end
    end

    // Read data is captured in setup so it stands with pready in the access cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.pready  <= apb_req.psel && !apb_req.penable;
            rsp_reg.pslverr <= apb_req.psel && !apb_req.penable && !mapped;
            if (rd_acc) begin
                rsp_reg.prdata <= rd_next;
            end
        end
    end

    assign apb_rsp       = rsp_reg;
    assign beat_ready    = ready_reg;
    assign chan_run      = cs_reg[CS_RUN_BIT];
    assign chan_dev_addr = dev_addr_reg;
    assign irq           = irq_reg;
endmodule : dmachr_channel

//--- verification/dmachr_properties.sv
// Checker: APB, stream and control relations of the DMA channel block
module dmachr_properties
    import dmachr_pkg::*;
(
    input wire logic            sys_clk,
    input wire logic            rst,
    input wire dmachr_apb_req_t apb_req,
    input wire dmachr_apb_rsp_t apb_rsp,
    input wire dmachr_beat_t    beat,
    input wire logic            beat_ready,
    input wire logic            chan_run,
    input wire logic [31:0]     chan_dev_addr,
    input wire logic            irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0]  a;
    logic [31:0] q;
    logic        wr;
    logic        rd;
    logic        tk;
    assign a = apb_req.paddr;
    assign q = apb_rsp.prdata;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign rd = apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite;
    assign tk = beat.valid && beat_ready;
    AST_SETUP_READY: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    AST_CNT_UPPER: assert property (rd && (a == OFF_CNT_A || a == OFF_CNT_B) |-> q[31:13] == 19'h0)
        else $error("count upper bits not zero");
    AST_CS_RSVD: assert property (rd && a == OFF_CS_READ |-> q[31:8] == 24'h0 && q[6:4] == 3'h0)
        else $error("reserved control bits set");
    AST_RUN_SET: assert property (wr && a == OFF_CS_SET && apb_req.pwdata[0] |=> chan_run)
        else $error("run not set");
    AST_RUN_CLR: assert property (wr && a == OFF_CS_CLR && apb_req.pwdata[0] |=> !chan_run)
        else $error("run not cleared");
    AST_BUS_ERR: assert property (tk && beat.bus_error |=> !chan_run)
        else $error("run kept after bus error");
    AST_BEAT_GAP: assert property (tk |=> !beat_ready)
        else $error("ready right after a byte");
    AST_IDLE: assert property (!chan_run ##1 !chan_run |-> !beat_ready)
        else $error("ready while stopped");
    AST_DEV_ADDR: assert property (wr && a == OFF_DEV_ADDR |=> chan_dev_addr == $past(apb_req.pwdata))
        else $error("device address not stored");
    cover property (tk && beat.bus_error);
    cover property (rd && a == OFF_CS_READ && q[2]);
    cover property ($rose(irq));
endmodule : dmachr_properties

bind dmachr_channel dmachr_properties dmachr_properties_i (.sys_clk(sys_clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .beat(beat), .beat_ready(beat_ready),
    .chan_run(chan_run), .chan_dev_addr(chan_dev_addr), .irq(irq));

//--- verification/dmachr_fifo_model.sv
// Peripheral FIFO model: offers bytes up to a target, with optional gaps
module dmachr_fifo_model
    import dmachr_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         beat_ready,
    input  wire logic         slow,
    input  wire logic         err,
    input  wire logic [13:0]  fill,
    output      dmachr_beat_t beat,
    output      logic [13:0]  sent
);
    logic gap;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sent <= 14'h0;
            gap <= 1'b0;
        end else begin
            gap <= slow && !gap;
            sent <= sent + 14'(beat.valid && beat_ready);
        end
    end
    assign beat.valid = (sent < fill) && !gap;
    // Error flag scrambled when no byte is offered
    assign beat.bus_error = beat.valid ? err : !err;
endmodule : dmachr_fifo_model

//--- verification/testbench.sv
// Testbench: APB register tests and byte stream for the DMA channel block
module testbench import dmachr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic            sys_clk = 1'b0;
    logic            rst = 1'b1;
    logic            slow = 1'b1;
    logic            err = 1'b0;
    logic [13:0]     fill = 14'h0;
    logic [13:0]     sent;
    logic            run;
    logic            irq;
    logic            rdy;
    logic            slv;
    logic [31:0]     dev;
    logic [31:0]     q;
    dmachr_apb_req_t req = '0;
    dmachr_apb_rsp_t rsp;
    dmachr_beat_t    beat;
    int              mismatches = 0;
    int              checked = 0;
    logic [31:0]     tbl [6] = '{32'h818002a8, 32'h818002b9, 32'h818003c8,
                                 32'h818003d9, 32'h81c01be8, 32'h81c01bf9};
    always #50 sys_clk = ~sys_clk;
    dmachr_channel #(.DEV_ADDR_TOP_FILL(32'hfc000000)) dmachr_channel_i (.sys_clk(sys_clk),
        .rst(rst), .apb_req(req), .apb_rsp(rsp), .beat(beat), .beat_ready(rdy),
        .chan_run(run), .chan_dev_addr(dev), .irq(irq));
    dmachr_fifo_model dmachr_fifo_model_i (.sys_clk(sys_clk), .rst(rst), .beat_ready(rdy),
        .slow(slow), .err(err), .fill(fill), .beat(beat), .sent(sent));
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Samples pready at the rising edge; the request stands until that edge
    task automatic x(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            mismatches++;
            results();
        end
        q = rsp.prdata;
        slv = rsp.pslverr;
        req <= '0;
    endtask : x
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        x(a, 1'b0, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic wait_sent(input logic [13:0] t);
        for (int n = 0; sent !== t; n++) begin
            if (n > 200) begin
                mismatches++;
                results();
            end
            @(negedge sys_clk);
        end
    endtask : wait_sent
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFF_CS_READ, 32'h0);
        rd(OFF_DEV_ADDR, 32'hfc000000);
        x(OFF_CNT_A, 1'b1, 32'hffffffff);
        rd(OFF_CNT_A, 32'h1fff);
        x(OFF_CNT_B, 1'b1, 32'hffffe000);
        rd(OFF_CNT_B, 32'h0);
        for (int i = 0; i < 6; i++) begin
            x(OFF_DEV_ADDR, 1'b1, tbl[i]);
            rd(OFF_DEV_ADDR, tbl[i]);
            check(dev, tbl[i]);
        end
        x(OFF_CS_CLR, 1'b1, 32'h7f);
        x(OFF_IRQ_EN, 1'b1, 32'h7);
        x(OFF_CNT_A, 1'b1, 32'h2);
        x(OFF_CNT_B, 1'b1, 32'h1);
        fill <= 14'h3;
        x(OFF_CS_SET, 1'b1, 32'h1);
        wait_sent(14'h3);
        check({31'h0, run}, 32'h1);
        rd(OFF_CS_READ, 32'h7);
        rd(OFF_CNT_A, 32'h0);
        rd(OFF_IRQ_STAT, 32'h3);
        check({31'h0, irq}, 32'h1);
        x(OFF_IRQ_CLR, 1'b1, 32'h3);
        rd(OFF_IRQ_STAT, 32'h0);
        check({31'h0, irq}, 32'h0);
        x(OFF_CS_CLR, 1'b1, 32'h7f);
        x(OFF_CNT_A, 1'b1, 32'h4);
        err <= 1'b1;
        fill <= 14'h4;
        x(OFF_CS_SET, 1'b1, 32'h1);
        wait_sent(14'h4);
        rd(OFF_CS_READ, 32'h80);
        x(OFF_IRQ_EN, 1'b1, 32'h0);
        rd(OFF_IRQ_STAT, 32'h4);
        check({31'h0, irq}, 32'h0);
        rd(8'h40, 32'h0);
        check({31'h0, slv}, 32'h1);
        results();
    end
endmodule : testbench
